// ===== src/swm_pkg.sv
// Package: constants, field layout and carrier types for the write port
package swm_pkg;

   // ----------------------------------------------------------------
   // Data path geometry
   // ----------------------------------------------------------------
   localparam int DATA_W = 36;
   localparam int LANES = 4;
   localparam int LANE_W = 9;
   localparam int NIB_W = 4;
   localparam int BURST_AW = 4;
   localparam int WORD_AW = BURST_AW + 2;
   localparam int FIFO_DEPTH = 8;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CFG = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_IGNORED = 8'h08;
   localparam logic [7:0] OFS_DROPPED = 8'h0c;
   localparam logic [7:0] OFS_MEM_ADDR = 8'h10;
   localparam logic [7:0] OFS_MEM_DATA = 8'h14;

   localparam int CFG_MODE_LSB = 0;
   localparam int CFG_HOLD_BIT = 4;
   localparam logic [1:0] CFG_MODE_RST = 2'h3;
   localparam logic CFG_HOLD_RST = 1'b0;

   localparam int ST_LEVEL_LSB = 0;
   localparam int ST_FULL_BIT = 8;
   localparam int ST_EMPTY_BIT = 9;
   localparam int ST_OVF_BIT = 16;

   // Width configuration codes
   localparam logic [1:0] MODE_X8 = 2'h0;
   localparam logic [1:0] MODE_X9 = 2'h1;
   localparam logic [1:0] MODE_X18 = 2'h2;
   localparam logic [1:0] MODE_X36 = 2'h3;

   // One clock cycle of write data: the true-edge and complement-edge beats
   typedef struct packed {
      logic [BURST_AW-1:0] addr;
      logic upper;
      logic [DATA_W-1:0] data_r;
      logic [DATA_W-1:0] data_f;
      logic [DATA_W-1:0] en_r;
      logic [DATA_W-1:0] en_f;
   } swm_pair_s;

   localparam int PAIR_W = $bits(swm_pair_s);

endpackage

// ===== src/swm_write_port.sv
// Write port of a burst SRAM: lane-masked beat capture, FIFO and APB view
//
// Functional notes
// - x8, both nibble selects low: store 8 bits
// - x8, nibble 0 only: store bits 3:0
// - x8, nibble 1 only: store bits 7:4
// - x18, both byte selects low: store 18 bits
// - x18, byte 0 only: store bits 8:0
// - x18, byte 1 only: store bits 17:9
// - all selects high: beat writes nothing
// - x36, all four selects low: store 36 bits
// - x36, single select stores its lane only
// - x9, one select governs bits 8:0
// - mask sampled per edge, one per beat
// - masks count only inside a started write
// - four beats fill two cycles after address
// - write on consecutive rise is ignored
//
// Our own choices: the APB slave port and the placing of the registers.

// ------------------------------------------------------------------
// Synchronous FIFO
// ------------------------------------------------------------------
module swm_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH+1)-1:0] level
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] store [DEPTH];
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic push;
   logic pop;
   assign in_ready = (level != DEPTH[$clog2(DEPTH+1)-1:0]);
   assign out_valid = (level != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = store[rd_ptr];
   always_ff @(posedge pclk) begin
      if (push) begin
         store[wr_ptr] <= in_data;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            level <= level + 1'b1;
         end else if (pop && !push) begin
            level <= level - 1'b1;
         end
      end
   end
endmodule

// ------------------------------------------------------------------
// Top of the write port
// ------------------------------------------------------------------
module swm_write_port
   import swm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic write_port_select_n,
   input wire logic [BURST_AW-1:0] wr_addr,
   input wire logic [DATA_W-1:0] wr_data_rise,
   input wire logic [DATA_W-1:0] wr_data_fall,
   input wire logic [LANES-1:0] byte_lane_write_mask_rise,
   input wire logic [LANES-1:0] byte_lane_write_mask_fall,
   output logic wr_ready
);

   // ----------------------------------------------------------------
   // Lane decode, shared by both edges
   // ----------------------------------------------------------------
   // Mask bits are active low; x8 uses bits 1:0 as the nibble selects
   function automatic logic [DATA_W-1:0] lane_enable(
      input logic [1:0] mode,
      input logic [LANES-1:0] mask_n
   );
      logic [DATA_W-1:0] en;
      en = '0;
      case (mode)
         MODE_X8: begin
            en[NIB_W-1:0] = {NIB_W{~mask_n[0]}};
            en[2*NIB_W-1:NIB_W] = {NIB_W{~mask_n[1]}};
         end
         MODE_X9: en[LANE_W-1:0] = {LANE_W{~mask_n[0]}};
         MODE_X18: begin
            en[LANE_W-1:0] = {LANE_W{~mask_n[0]}};
            en[2*LANE_W-1:LANE_W] = {LANE_W{~mask_n[1]}};
         end
         default: begin
            for (int i = 0; i < LANES; i++) begin
               en[i*LANE_W +: LANE_W] = {LANE_W{~mask_n[i]}};
            end
         end
      endcase
      // All selects high leaves en at zero: nothing stored
      // Lanes are decoded one by one, so mixed masks just work
      return en;
   endfunction

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   localparam int PIN_W = 1 + BURST_AW + 2 * DATA_W + 2 * LANES;
   logic [PIN_W-1:0] pin_meta;
   logic [PIN_W-1:0] pin_sync;
   logic sel_n_s;
   logic [BURST_AW-1:0] addr_s;
   logic [DATA_W-1:0] data_r_s;
   logic [DATA_W-1:0] data_f_s;
   logic [LANES-1:0] mask_r_s;
   logic [LANES-1:0] mask_f_s;
   // Select idles high so reset does not fake a write request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta <= {1'b1, {(PIN_W-1){1'b0}}};
         pin_sync <= {1'b1, {(PIN_W-1){1'b0}}};
      end else begin
         pin_meta <= {write_port_select_n, wr_addr, wr_data_rise,
                      wr_data_fall, byte_lane_write_mask_rise,
                      byte_lane_write_mask_fall};
         pin_sync <= pin_meta;
      end
   end
   // All pins share one delay, so beats stay aligned with their request
   assign {sel_n_s, addr_s, data_r_s, data_f_s, mask_r_s, mask_f_s} =
      pin_sync;

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   logic [1:0] cfg_mode;
   logic cfg_hold;
   logic ovf_flag;
   logic [15:0] ignored_cnt;
   logic [15:0] dropped_cnt;
   logic [WORD_AW-1:0] mem_addr;

   // ----------------------------------------------------------------
   // Write burst sequencing
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {ph_idle, ph_first, ph_second} swm_phase_e;
   swm_phase_e phase;
   swm_phase_e next_phase;
   logic [BURST_AW-1:0] burst_addr;
   logic req_take;
   logic req_drop;
   // A request right after an accepted one is discarded
   assign req_take = !sel_n_s && (phase != ph_first);
   assign req_drop = !sel_n_s && (phase == ph_first);
   always_comb begin
      next_phase = ph_idle;
      case (phase)
         ph_idle: next_phase = req_take ? ph_first : ph_idle;
         ph_first: next_phase = ph_second;
         ph_second: next_phase = req_take ? ph_first : ph_idle;
         default: next_phase = ph_idle;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase <= ph_idle;
         burst_addr <= '0;
      end else begin
         phase <= next_phase;
         if (req_take) begin
            burst_addr <= addr_s;
         end
      end
   end

   // ----------------------------------------------------------------
   // Beat capture into the FIFO
   // ----------------------------------------------------------------
   swm_pair_s pair_in;
   swm_pair_s pair_out;
   logic pair_valid;
   logic pair_out_valid;
   logic pair_out_ready;
   logic [$clog2(FIFO_DEPTH+1)-1:0] fifo_level;
   logic [PAIR_W-1:0] pair_out_bits;
   // Only cycles that carry data of an accepted write count
   assign pair_valid = (phase != ph_idle);
   assign pair_in.addr = burst_addr;
   assign pair_in.upper = (phase == ph_second);
   assign pair_in.data_r = data_r_s;
   assign pair_in.data_f = data_f_s;
   // Each edge has its own mask, taken with its own beat
   assign pair_in.en_r = lane_enable(cfg_mode, mask_r_s);
   assign pair_in.en_f = lane_enable(cfg_mode, mask_f_s);
   swm_fifo #(
      .WIDTH(PAIR_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .in_valid(pair_valid),
      .in_ready(wr_ready),
      .in_data(pair_in),
      .out_valid(pair_out_valid),
      .out_ready(pair_out_ready),
      .out_data(pair_out_bits),
      .level(fifo_level)
   );
   assign pair_out = swm_pair_s'(pair_out_bits);

   // ----------------------------------------------------------------
   // Array update
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] mem [2**WORD_AW];
   logic [WORD_AW-1:0] idx_r;
   logic [WORD_AW-1:0] idx_f;
   logic apb_mem_rd;

   // Draining pauses while software holds it or reads the array, so a
   // read never sees half a beat pair; the FIFO absorbs the stall
   assign apb_mem_rd = psel && (paddr == OFS_MEM_DATA) && !pwrite;
   assign pair_out_ready = !cfg_hold && !apb_mem_rd;
   assign idx_r = {pair_out.addr, pair_out.upper, 1'b0};
   assign idx_f = {pair_out.addr, pair_out.upper, 1'b1};

   // Storage has no reset, like the array it models
   always_ff @(posedge pclk) begin
      if (pair_out_valid && pair_out_ready) begin
         mem[idx_r] <= (mem[idx_r] & ~pair_out.en_r) |
                       (pair_out.data_r & pair_out.en_r);
         mem[idx_f] <= (mem[idx_f] & ~pair_out.en_f) |
                       (pair_out.data_f & pair_out.en_f);
      end
   end

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   logic ack;
   logic acc;
   logic wr_acc;
   logic mapped;
   // One wait state: the read word is registered before pready
   assign acc = psel && penable && !ack;
   assign pready = psel && penable && ack;
   assign wr_acc = pready && pwrite;
   always_comb begin
      if (paddr inside {OFS_CFG, OFS_STATUS, OFS_IGNORED, OFS_DROPPED,
                        OFS_MEM_ADDR, OFS_MEM_DATA}) begin
         mapped = 1'b1;
      end else begin
         mapped = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         ack <= acc;
         pslverr <= acc && !mapped;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (acc && !pwrite) begin
         prdata <= '0;
         if (paddr == OFS_CFG) begin
            prdata[CFG_MODE_LSB +: 2] <= cfg_mode;
            prdata[CFG_HOLD_BIT] <= cfg_hold;
         end else if (paddr == OFS_STATUS) begin
            prdata[ST_LEVEL_LSB +: $bits(fifo_level)] <= fifo_level;
            prdata[ST_FULL_BIT] <= !wr_ready;
            prdata[ST_EMPTY_BIT] <= !pair_out_valid;
            prdata[ST_OVF_BIT] <= ovf_flag;
         end else if (paddr == OFS_IGNORED) begin
            prdata[15:0] <= ignored_cnt;
         end else if (paddr == OFS_DROPPED) begin
            prdata[15:0] <= dropped_cnt;
         end else if (paddr == OFS_MEM_ADDR) begin
            prdata[WORD_AW-1:0] <= mem_addr;
         end else if (paddr == OFS_MEM_DATA) begin
            // Bits 35:32 of an array word have no place in a bus word
            prdata <= mem[mem_addr][31:0];
         end
      end else begin
         prdata <= '0;
      end
   end
   // Configuration and array pointer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_mode <= CFG_MODE_RST;
         cfg_hold <= CFG_HOLD_RST;
         mem_addr <= '0;
      end else if (wr_acc && mapped) begin
         if (paddr == OFS_CFG) begin
            cfg_mode <= pwdata[CFG_MODE_LSB +: 2];
            cfg_hold <= pwdata[CFG_HOLD_BIT];
         end else if (paddr == OFS_MEM_ADDR) begin
            mem_addr <= pwdata[WORD_AW-1:0];
         end
      end
   end

   // Overflow flag: a new loss wins over a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovf_flag <= 1'b0;
      end else if (pair_valid && !wr_ready) begin
         ovf_flag <= 1'b1;
      end else if (wr_acc && paddr == OFS_STATUS && pwdata[ST_OVF_BIT]) begin
         ovf_flag <= 1'b0;
      end
   end

   // Counters saturate; a write to a counter clears it unless a new event arrives in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ignored_cnt <= '0;
      end else if (req_drop && ignored_cnt != 16'hffff) begin
         ignored_cnt <= ignored_cnt + 16'h0001;
      end else if (wr_acc && paddr == OFS_IGNORED && !req_drop) begin
         ignored_cnt <= '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dropped_cnt <= '0;
      end else if (pair_valid && !wr_ready && dropped_cnt != 16'hffff) begin
         dropped_cnt <= dropped_cnt + 16'h0001;
      end else if (wr_acc && paddr == OFS_DROPPED &&
                   !(pair_valid && !wr_ready)) begin
         dropped_cnt <= '0;
      end
   end
endmodule

// ===== dv/swm_write_port_sva.sv
// Checker: APB answer timing and error reporting of the write port
module swm_write_port_sva
   import swm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // ----------------------------------------------------------------
   // Transfer phases
   // ----------------------------------------------------------------
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence wait_s;
      setup_s ##1 (psel && penable);
   endsequence
   wire logic mapped = paddr <= OFS_MEM_DATA && paddr[1:0] == 2'h0;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   setup_quiet_a: assert property (setup_s |-> !pready)
      else $error("pready during setup");
   one_wait_a: assert property (wait_s |-> !pready)
      else $error("pready in first access cycle");
   ready_second_a: assert property (wait_s ##1 (psel && penable) |-> pready)
      else $error("pready missing in second access cycle");
   idle_quiet_a: assert property (!psel |-> !pready && prdata == 32'h0)
      else $error("answer outside a transfer");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   bad_addr_a: assert property (pready && !mapped |-> pslverr)
      else $error("unmapped address not refused");
   good_addr_a: assert property (pready && mapped |-> !pslverr)
      else $error("mapped address refused");
   write_rdata_a: assert property (pready && pwrite |-> prdata == 32'h0)
      else $error("read data during a write");
endmodule

bind swm_write_port swm_write_port_sva i_sva (
   .pclk(pclk),
   .presetn(presetn),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .prdata(prdata),
   .pready(pready),
   .pslverr(pslverr)
);

// ===== dv/swm_ctrl_model.sv
// Model of the memory controller that drives the write link
module swm_ctrl_model
   import swm_pkg::*;
(
   input wire logic pclk,
   output logic write_port_select_n,
   output logic [BURST_AW-1:0] wr_addr,
   output logic [DATA_W-1:0] wr_data_rise,
   output logic [DATA_W-1:0] wr_data_fall,
   output logic [LANES-1:0] byte_lane_write_mask_rise,
   output logic [LANES-1:0] byte_lane_write_mask_fall
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      write_port_select_n = 1'b1;
      wr_addr = '0;
      wr_data_rise = '0;
      wr_data_fall = '1;
      byte_lane_write_mask_rise = '0;
      byte_lane_write_mask_fall = '1;
   end

   // Request, then four beats in the next two cycles
   task automatic burst(input logic [BURST_AW-1:0] a,
      input logic [143:0] d, input logic [15:0] m, input bit dbl);
      @(posedge pclk);
      write_port_select_n <= 1'b0;
      wr_addr <= a;
      for (int c = 0; c < 2; c++) begin
         @(posedge pclk);
         // Optional illegal second request right behind
         write_port_select_n <= !(dbl && c == 0);
         wr_addr <= ~a;
         wr_data_rise <= d[72*c +: 36];
         wr_data_fall <= d[72*c+36 +: 36];
         byte_lane_write_mask_rise <= m[8*c +: 4];
         byte_lane_write_mask_fall <= m[8*c+4 +: 4];
      end
      @(posedge pclk);
      // Released lines invert, so stale masks may look enabled
      write_port_select_n <= 1'b1;
      wr_data_rise <= ~wr_data_rise;
      wr_data_fall <= ~wr_data_fall;
      byte_lane_write_mask_rise <= ~byte_lane_write_mask_rise;
      byte_lane_write_mask_fall <= ~byte_lane_write_mask_fall;
   endtask
endmodule

// ===== dv/swm_write_port_tb.sv
// Testbench: lane masks per mode, refused requests, FIFO overflow
module swm_write_port_tb
   import swm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic sel_n, wr_ready;
   logic [BURST_AW-1:0] wa;
   logic [DATA_W-1:0] dr, df;
   logic [LANES-1:0] mr, mf;
   logic [1:0] md;
   logic [35:0] mem [64];
   int n_errors = 0;
   int checked = 0;
   int n;

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   swm_write_port i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .write_port_select_n(sel_n), .wr_addr(wa), .wr_data_rise(dr),
      .wr_data_fall(df), .byte_lane_write_mask_rise(mr),
      .byte_lane_write_mask_fall(mf), .wr_ready(wr_ready));
   swm_ctrl_model i_ctrl (.pclk(pclk), .write_port_select_n(sel_n),
      .wr_addr(wa), .wr_data_rise(dr), .wr_data_fall(df),
      .byte_lane_write_mask_rise(mr), .byte_lane_write_mask_fall(mf));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, exp, input string s);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %s got %h exp %h", $time, s, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] wd);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k == 20) begin
         n_errors++;
         $display("wrong value at %0t: no pready", $time);
         end_sim();
      end
   endtask

   // Bits that a beat writes for a mode and active-low selects
   function automatic logic [35:0] lanes(input logic [1:0] m,
      input logic [3:0] s);
      logic [35:0] e;
      e = '0;
      case (m)
         MODE_X8: e[7:0] = {{4{~s[1]}}, {4{~s[0]}}};
         MODE_X9: e[8:0] = {9{~s[0]}};
         MODE_X18: e[17:0] = {{9{~s[1]}}, {9{~s[0]}}};
         default: for (int i = 0; i < 4; i++) e[9*i +: 9] = {9{~s[i]}};
      endcase
      return e;
   endfunction

   function automatic logic [143:0] rnd();
      return {$urandom(), $urandom(), $urandom(), $urandom(), 16'($urandom())};
   endfunction

   task automatic wr(input logic [3:0] a, input logic [143:0] d,
      input logic [15:0] m, input bit dbl, input bit keep);
      logic [35:0] e;
      i_ctrl.burst(a, d, m, dbl);
      for (int k = 0; k < 4; k++) begin
         e = keep ? lanes(md, m[4*k +: 4]) : 36'h0;
         mem[4*a+k] = (mem[4*a+k] & ~e) | (d[36*k +: 36] & e);
      end
   endtask

   task automatic chk(input logic [3:0] a);
      logic [35:0] w;
      w = lanes(md, 4'h0);
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, OFS_MEM_ADDR, {26'h0, a, 2'(k)});
         apb(1'b0, OFS_MEM_DATA, 32'h0);
         cmp(rd & w[31:0], mem[4*a+k][31:0] & w[31:0], "word");
      end
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h0;
      pwdata = 32'h0;
      md = MODE_X36;
      void'($urandom(20));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      apb(1'b0, OFS_CFG, 32'h0);
      cmp(rd, 32'h3, "cfg reset");
      apb(1'b0, OFS_STATUS, 32'h0);
      cmp(rd, 32'h200, "status reset");
      apb(1'b0, 8'h18, 32'h0);
      cmp({rd[30:0], er}, 32'h1, "unmapped");
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         md = 2'(i);
         apb(1'b1, OFS_CFG, {30'h0, md});
         wr(4'(i), rnd(), 16'h0, 0, 1);
         wr(4'(i), rnd(), 16'hfde0, 0, 1);
         chk(4'(i));
         $display("test mode %0d done", i);
      end
      md = MODE_X36;
      apb(1'b1, OFS_CFG, 32'h3);
      for (int i = 0; i < 16; i++) wr(4'(i), rnd(), 16'h0, 0, 1);
      for (int i = 0; i < 24; i++) wr(4'($urandom()), rnd(),
         16'($urandom()), 0, 1);
      for (int i = 0; i < 16; i++) chk(4'(i));
      $display("test random masks done");
      apb(1'b1, OFS_IGNORED, 32'h0);
      wr(4'h5, rnd(), 16'h0, 1, 1);
      chk(4'h5);
      chk(4'ha);
      apb(1'b0, OFS_IGNORED, 32'h0);
      cmp(rd, 32'h1, "ignored count");
      $display("test repeated request done");
      apb(1'b1, OFS_CFG, 32'h13);
      for (int i = 0; i < 4; i++) wr(4'(i), rnd(), 16'h0, 0, 1);
      apb(1'b0, OFS_STATUS, 32'h0);
      cmp({rd[31:1], wr_ready}, 32'h108, "fifo full");
      wr(4'h7, rnd(), 16'h0, 0, 0);
      apb(1'b0, OFS_STATUS, 32'h0);
      cmp(rd, 32'h10108, "overflow");
      apb(1'b0, OFS_DROPPED, 32'h0);
      cmp(rd, 32'h2, "dropped count");
      apb(1'b1, OFS_CFG, 32'h3);
      n = 0;
      do begin
         apb(1'b0, OFS_STATUS, 32'h0);
         n++;
      end while (rd[ST_EMPTY_BIT] !== 1'b1 && n < 20);
      if (rd[ST_EMPTY_BIT] !== 1'b1) begin
         n_errors++;
         $display("wrong value at %0t: buffer never drained", $time);
         end_sim();
      end
      apb(1'b1, OFS_STATUS, 32'h10000);
      apb(1'b0, OFS_STATUS, 32'h0);
      cmp(rd, 32'h200, "drained");
      for (int i = 0; i < 8; i++) chk(4'(i));
      $display("test buffer done");
      end_sim();
   end
endmodule
